// >>> rtl/sesp_pkg.sv
// Shared constants for the two-wire EEPROM slave port.
// Assumes a 100 MHz system clock and a serial clock of at most 1 MHz.
package sesp_pkg;
  // ==========================================================
  // Timing
  localparam int CLK_HZ = 100_000_000;
  localparam int T_WR_MS = 3; // Longest self-timed program time
  localparam int WR_CYCLES = T_WR_MS * (CLK_HZ / 1000); // Rounded down
  // ==========================================================
  // Memory organisation
  localparam int PAGES = 512;
  localparam int PAGE_BYTES = 64;
  localparam int ARR_BYTES = PAGES * PAGE_BYTES;
  localparam int AW = 15; // Linear byte address width
  localparam int PW = 6; // Byte-in-page width
  localparam int LOCK_BIT = 10; // Id-type write with this bit set locks
  localparam int UID_BIT = 11; // Id-type read with this bit set reads the serial
  localparam logic [AW-1:0] PTR_RST = 15'h0000;
  localparam logic [127:0] UID_DEFAULT = 128'h0123_4567_89AB_CDEF_FEDC_BA98_7654_3210;
  // ==========================================================
  // Address byte and link bit counting
  localparam logic [3:0] TYPE_MAIN = 4'hA;
  localparam logic [3:0] TYPE_ID = 4'hB;
  localparam logic [3:0] BIT_ACK = 4'h8; // Eight bits taken, answer slot next
  // ==========================================================
  // Event word {is_id, kind, byte} from link to system side
  localparam int EVW = 12;
  localparam logic [2:0] EV_DEV = 3'h0;
  localparam logic [2:0] EV_AHI = 3'h1;
  localparam logic [2:0] EV_ALO = 3'h2;
  localparam logic [2:0] EV_WDAT = 3'h3;
  localparam logic [2:0] EV_RNEXT = 3'h4;
endpackage

// >>> rtl/sesp_mem.sv
// Single-port byte memory with registered read data.
// Assumes one clock; write and read address share one port.
`timescale 1ns/100ps
module sesp_mem #(
  parameter int DEPTH = 64,
  parameter int ABITS = 6
) (
  input wire logic clk_i, // System clock
  input wire logic we_i, // Write strobe
  input wire logic [ABITS-1:0] addr_i, // Byte address
  input wire logic [7:0] wdata_i, // Write byte
  output logic [7:0] rdata_o // Byte read last cycle
);
  logic [7:0] mem [DEPTH];

  // ==========================================================
  // Storage; no reset, contents are the erased array
  always_ff @(posedge clk_i) begin
    if (we_i) begin
      mem[addr_i] <= wdata_i;
    end
    rdata_o <= mem[addr_i];
  end
endmodule

// >>> rtl/sesp_top.sv
// Two-wire slave port of a serial EEPROM with write protection,
// staging page, self-timed commit, lockable id page and serial number.
// Assumes SCL_CLK_I runs only during frames at 1 MHz or less.
`timescale 1ns/100ps
module sesp_top import sesp_pkg::*; #(
  parameter int WRITE_CYCLES = WR_CYCLES, // Commit length in clock cycles
  parameter logic [127:0] UNIQUE_ID = UID_DEFAULT // Arbitrary value
) (
  input wire logic SYS_CLK_I, // System clock
  input wire logic SYS_RST_I, // Synchronous reset, high
  input wire logic SCL_CLK_I, // Serial clock from the master
  input wire logic SDA_I, // Data line level
  output logic SDA_O, // Data line drive value, always low
  output logic SDA_OE_N_O, // Low while pulling the line low
  input wire logic CHIP_SELECT_BIT_0_I, // Select strap 0
  input wire logic CHIP_SELECT_BIT_1_I, // Select strap 1
  input wire logic CHIP_SELECT_BIT_2_I, // Select strap 2
  input wire logic WRITE_PROTECT_I, // High makes the device read-only
  output logic BUSY_O // Commit in progress
);
  typedef enum logic [2:0] {L_DEV, L_AHI, L_ALO, L_WDATA, L_RSTART, L_RDATA,
                            L_IGNORE} sesp_link_t;
  typedef enum logic [1:0] {C_IDLE, C_COPY, C_WAIT} sesp_cmt_t;

  logic [2:0] scl_q, sda_q, tgl_q;
  logic start_det, stop_det, link_clr, link_rst;
  logic [7:0] shreg, tx, rd_byte;
  logic [3:0] bitcnt;
  logic [4:0] sy_a, sy_b;
  logic [2:0] cs_s;
  logic wp_s, busy_s, lock_m, lock_s, pull_low, is_id, dev_match, wr_refused;
  sesp_link_t lst;
  logic [EVW-1:0] ev_word, pend_word, f0, f1;
  logic ev_tgl, pend, push, pop;
  logic [1:0] fcnt;
  logic [AW-1:0] ptr;
  logic rd_id, wr_pend, wr_id, wr_lock, locked, busy, cp_v;
  logic [PW-1:0] cp_i, wr_page_lo;
  logic [AW-PW-1:0] wr_page;
  logic [PAGE_BYTES-1:0] mask;
  logic [6:0] idx;
  logic [18:0] wcnt;
  sesp_cmt_t cst;
  logic [7:0] main_q, id_q, pbuf_q;
  logic pbuf_we, main_we, id_we;

  // ==========================================================
  // System side view of the bus lines
  // Stage 0 feeds stage 1 only; edges come from stages 1 and 2
  always_ff @(posedge SYS_CLK_I) begin
    if (SYS_RST_I) begin
      scl_q <= 3'h7;
      sda_q <= 3'h7;
    end else begin
      scl_q <= {scl_q[1:0], SCL_CLK_I};
      sda_q <= {sda_q[1:0], SDA_I};
    end
  end
  assign start_det = scl_q[1] & scl_q[2] & sda_q[2] & ~sda_q[1];
  assign stop_det = scl_q[1] & scl_q[2] & ~sda_q[2] & sda_q[1];

  // Clears for the link logic, which has no clock between frames
  always_ff @(posedge SYS_CLK_I) begin
    link_clr <= SYS_RST_I | start_det | stop_det;
    link_rst <= SYS_RST_I;
  end

  // ==========================================================
  // Link side: bit capture on the rising serial clock
  always_ff @(posedge SCL_CLK_I or posedge link_clr) begin
    if (link_clr) begin
      shreg <= 8'h00;
      bitcnt <= 4'h0;
    end else begin
      shreg <= {shreg[6:0], SDA_I};
      bitcnt <= (bitcnt == BIT_ACK) ? 4'h0 : bitcnt + 4'h1;
    end
  end

  // Straps and system levels, two stages on the serial clock
  // Pad pull-downs make a floating strap or protect pin read low
  always_ff @(posedge SCL_CLK_I) begin
    sy_a <= {CHIP_SELECT_BIT_2_I, CHIP_SELECT_BIT_1_I, CHIP_SELECT_BIT_0_I,
             WRITE_PROTECT_I, busy};
    sy_b <= sy_a;
  end
  assign cs_s = sy_b[4:2];
  assign wp_s = sy_b[1];
  assign busy_s = sy_b[0];
  // Locked only ever rises; two stages still, as it comes from the system clock
  always_ff @(posedge SCL_CLK_I or posedge link_rst) begin
    if (link_rst) begin
      lock_m <= 1'b0;
      lock_s <= 1'b0;
    end else begin
      lock_m <= locked;
      lock_s <= lock_m;
    end
  end

  assign dev_match = (shreg[7:5] == TYPE_MAIN[3:1]) && (shreg[3:1] == cs_s)
                     && !busy_s;
  assign wr_refused = wp_s || (is_id && lock_s);

  // ==========================================================
  // Link side: answers and outgoing bits on the falling clock
  always_ff @(negedge SCL_CLK_I or posedge link_clr) begin
    if (link_clr) begin
      lst <= L_DEV;
      pull_low <= 1'b0;
      is_id <= 1'b0;
      tx <= 8'h00;
    end else if (bitcnt == BIT_ACK) begin
      case (lst)
        L_DEV: begin
          pull_low <= dev_match;
          is_id <= shreg[4];
          lst <= !dev_match ? L_IGNORE : (shreg[0] ? L_RSTART : L_AHI);
        end
        L_AHI: begin
          pull_low <= 1'b1;
          lst <= L_ALO;
        end
        L_ALO: begin
          pull_low <= 1'b1;
          lst <= L_WDATA;
        end
        L_WDATA: pull_low <= !wr_refused;
        default: pull_low <= 1'b0; // Master answers a read byte
      endcase
    end else if (bitcnt == 4'h0) begin
      // Load a byte after the address ack or a master ack
      if (lst == L_RSTART || (lst == L_RDATA && !shreg[0])) begin
        tx <= {rd_byte[6:0], 1'b0};
        pull_low <= !rd_byte[7];
        lst <= L_RDATA;
      end else begin
        pull_low <= 1'b0;
        if (lst == L_RDATA) begin
          lst <= L_IGNORE;
        end
      end
    end else if (lst == L_RDATA) begin
      pull_low <= !tx[7];
      tx <= {tx[6:0], 1'b0};
    end
  end
  assign SDA_O = 1'b0;
  assign SDA_OE_N_O = !pull_low;

  // Events handed to the system side, one per byte at most
  // The word stays put for nine serial clocks, far longer than the crossing
  always_ff @(negedge SCL_CLK_I or posedge link_rst) begin
    if (link_rst) begin
      ev_tgl <= 1'b0;
      ev_word <= '0;
    end else if (bitcnt == BIT_ACK && !link_clr) begin
      if (lst == L_DEV && dev_match) begin
        ev_word <= {shreg[4], EV_DEV, shreg};
        ev_tgl <= !ev_tgl;
      end else if (lst == L_AHI || lst == L_ALO || (lst == L_WDATA && !wr_refused)) begin
        ev_word <= {is_id, (lst == L_AHI) ? EV_AHI : (lst == L_ALO) ? EV_ALO : EV_WDAT,
                    shreg};
        ev_tgl <= !ev_tgl;
      end else if (lst == L_RDATA) begin
        ev_word <= {is_id, EV_RNEXT, 8'h00};
        ev_tgl <= !ev_tgl;
      end
    end
  end

  // ==========================================================
  // System side: event capture, held until the buffer takes it
  always_ff @(posedge SYS_CLK_I) begin
    if (SYS_RST_I) begin
      tgl_q <= 3'h0;
      pend <= 1'b0;
      pend_word <= '0;
    end else begin
      tgl_q <= {tgl_q[1:0], ev_tgl};
      if (tgl_q[2] ^ tgl_q[1]) begin
        pend <= 1'b1;
        pend_word <= ev_word;
      end else if (push) begin
        pend <= 1'b0;
      end
    end
  end

  // Two-entry buffer; drains only while no commit runs
  assign push = pend && (fcnt != 2'h2);
  assign pop = (fcnt != 2'h0) && (cst == C_IDLE);
  always_ff @(posedge SYS_CLK_I) begin
    if (SYS_RST_I) begin
      fcnt <= 2'h0;
      f0 <= '0;
      f1 <= '0;
    end else begin
      if (pop) begin
        f0 <= (fcnt == 2'h1) ? pend_word : f1;
      end else if (push && fcnt == 2'h0) begin
        f0 <= pend_word;
      end
      if (push && fcnt == (pop ? 2'h2 : 2'h1)) begin
        f1 <= pend_word;
      end
      fcnt <= fcnt + {1'b0, push} - {1'b0, pop};
    end
  end

  // ==========================================================
  // Pointer and staging of written bytes
  assign pbuf_we = pop && f0[10:8] == EV_WDAT;
  always_ff @(posedge SYS_CLK_I) begin
    if (SYS_RST_I) begin
      ptr <= PTR_RST;
      rd_id <= 1'b0;
      wr_pend <= 1'b0;
      wr_id <= 1'b0;
      wr_lock <= 1'b0;
      wr_page <= '0;
      mask <= '0;
    end else if (cst == C_WAIT && wcnt == 19'(WRITE_CYCLES - 1)) begin
      wr_pend <= 1'b0;
      mask <= '0;
    end else if (pop) begin
      case (f0[10:8])
        EV_DEV: begin
          rd_id <= f0[11];
          wr_pend <= 1'b0; // A new command drops an uncommitted page
          mask <= '0;
        end
        EV_AHI: ptr[AW-1:8] <= f0[AW-9:0];
        EV_ALO: ptr[7:0] <= f0[7:0];
        EV_WDAT: begin
          ptr[PW-1:0] <= ptr[PW-1:0] + 6'h01;
          mask[ptr[PW-1:0]] <= 1'b1;
          wr_pend <= 1'b1;
          wr_id <= f0[11];
          wr_lock <= f0[11] && ptr[LOCK_BIT];
          wr_page <= ptr[AW-1:PW];
        end
        EV_RNEXT: begin
          if (rd_id) begin
            ptr[PW-1:0] <= ptr[PW-1:0] + 6'h01;
          end else begin
            ptr <= ptr + 15'h0001;
          end
        end
        default: ptr <= ptr;
      endcase
    end
  end

  // ==========================================================
  // Self-timed commit of the staged page
  always_ff @(posedge SYS_CLK_I) begin
    if (SYS_RST_I) begin
      cst <= C_IDLE;
      busy <= 1'b0;
      locked <= 1'b0;
      idx <= 7'h00;
      wcnt <= 19'h00000;
    end else begin
      case (cst)
        C_IDLE: if (stop_det && wr_pend) begin
          cst <= C_COPY;
          busy <= 1'b1;
          idx <= 7'h00;
          wcnt <= 19'h00000;
          if (wr_lock) begin
            locked <= 1'b1;
          end
        end
        C_COPY: begin
          idx <= idx + 7'h01;
          wcnt <= wcnt + 19'h00001;
          if (idx == 7'(PAGE_BYTES - 1)) begin
            cst <= C_WAIT;
          end
        end
        C_WAIT: begin
          wcnt <= wcnt + 19'h00001;
          if (wcnt == 19'(WRITE_CYCLES - 1)) begin
            cst <= C_IDLE;
            busy <= 1'b0;
          end
        end
        default: cst <= C_IDLE;
      endcase
    end
  end
  assign BUSY_O = busy;

  // Copy pipeline: staging byte arrives a cycle after its index
  always_ff @(posedge SYS_CLK_I) begin
    if (SYS_RST_I) begin
      cp_v <= 1'b0;
      cp_i <= '0;
    end else begin
      cp_v <= (cst == C_COPY);
      cp_i <= idx[PW-1:0];
    end
  end
  assign main_we = cp_v && mask[cp_i] && !wr_id;
  assign id_we = cp_v && mask[cp_i] && wr_id && !wr_lock && !locked;
  assign wr_page_lo = (cst == C_COPY) ? idx[PW-1:0] : ptr[PW-1:0];

  // ==========================================================
  // Storage
  sesp_mem #(.DEPTH(ARR_BYTES), .ABITS(AW)) u_main (
    .clk_i(SYS_CLK_I),
    .we_i(main_we),
    .addr_i(cp_v ? {wr_page, cp_i} : ptr),
    .wdata_i(pbuf_q),
    .rdata_o(main_q)
  );
  sesp_mem #(.DEPTH(PAGE_BYTES), .ABITS(PW)) u_idpg (
    .clk_i(SYS_CLK_I),
    .we_i(id_we),
    .addr_i(cp_v ? cp_i : ptr[PW-1:0]),
    .wdata_i(pbuf_q),
    .rdata_o(id_q)
  );
  sesp_mem #(.DEPTH(PAGE_BYTES), .ABITS(PW)) u_stage (
    .clk_i(SYS_CLK_I),
    .we_i(pbuf_we),
    .addr_i(wr_page_lo),
    .wdata_i(f0[7:0]),
    .rdata_o(pbuf_q)
  );

  // Read byte offered to the link; quasi-static between bytes
  always_ff @(posedge SYS_CLK_I) begin
    if (SYS_RST_I) begin
      rd_byte <= 8'h00;
    end else if (!rd_id) begin
      rd_byte <= main_q;
    end else if (ptr[UID_BIT]) begin
      rd_byte <= 8'(UNIQUE_ID >> (8 * (15 - int'(ptr[3:0]))));
    end else begin
      rd_byte <= id_q;
    end
  end

  // ==========================================================
  // Checks
  property p_addr_mismatch_nack;
    @(negedge SCL_CLK_I) disable iff (link_clr)
    (bitcnt == BIT_ACK && lst == L_DEV && shreg[3:1] != cs_s) |=> !pull_low;
  endproperty
  a_addr_mismatch_nack: assert property (p_addr_mismatch_nack)
    else $error("Address byte acked with wrong select bits");
  property p_busy_nack;
    @(negedge SCL_CLK_I) disable iff (link_clr)
    (bitcnt == BIT_ACK && lst == L_DEV && busy_s) |=> (!pull_low && lst == L_IGNORE);
  endproperty
  a_busy_nack: assert property (p_busy_nack)
    else $error("Address acked during commit");
  property p_wp_nack;
    @(negedge SCL_CLK_I) disable iff (link_clr)
    (bitcnt == BIT_ACK && lst == L_WDATA && wp_s) |=> !pull_low ##1 !pull_low;
  endproperty
  a_wp_nack: assert property (p_wp_nack)
    else $error("Data byte acked under write protect");
  property p_data_ack;
    @(negedge SCL_CLK_I) disable iff (link_clr)
    (bitcnt == BIT_ACK && lst inside {L_AHI, L_ALO} ||
     bitcnt == BIT_ACK && lst == L_WDATA && !wr_refused) |=> pull_low;
  endproperty
  a_data_ack: assert property (p_data_ack)
    else $error("Accepted byte not acked");
  property p_stop_commit;
    @(posedge SYS_CLK_I) disable iff (SYS_RST_I)
    (stop_det && wr_pend && cst == C_IDLE) |=> busy ##64 (cst == C_WAIT);
  endproperty
  a_stop_commit: assert property (p_stop_commit)
    else $error("Stop after write did not start commit");
  property p_commit_bound;
    @(posedge SYS_CLK_I) disable iff (SYS_RST_I)
    busy |-> wcnt < 19'(WRITE_CYCLES);
  endproperty
  a_commit_bound: assert property (p_commit_bound)
    else $error("Commit exceeded its time");
  property p_page_wrap;
    @(posedge SYS_CLK_I) disable iff (SYS_RST_I)
    pbuf_we |=> ptr[AW-1:PW] == $past(ptr[AW-1:PW]);
  endproperty
  a_page_wrap: assert property (p_page_wrap)
    else $error("Write pointer left its page");
  property p_lock_hold;
    @(posedge SYS_CLK_I) disable iff (SYS_RST_I)
    locked |-> !id_we ##1 locked;
  endproperty
  a_lock_hold: assert property (p_lock_hold)
    else $error("Locked id page written or unlocked");
  property p_write_protect_quiet;
    @(negedge SCL_CLK_I) disable iff (link_clr)
    (bitcnt == BIT_ACK && lst == L_WDATA && wp_s) |=> $stable(ev_tgl);
  endproperty
  a_write_protect_quiet: assert property (p_write_protect_quiet)
    else $error("Protected data byte passed on");
  c_commit: cover property (@(posedge SYS_CLK_I) cst == C_IDLE ##1 cst == C_COPY);
  c_read: cover property (@(negedge SCL_CLK_I) lst == L_RSTART ##1 lst == L_RDATA);
  c_wp: cover property (@(negedge SCL_CLK_I) bitcnt == BIT_ACK && lst == L_WDATA && wp_s);
endmodule

// >>> sim/sesp_master.sv
// Two-wire bus master model facing the EEPROM slave port.
// Assumes the bench resolves the pulled-up data line into sda_i.
`timescale 1ns/100ps
module sesp_master (
  input wire logic sda_i, // Resolved data line
  output logic scl_o, // Serial clock, high while idle
  output logic pull_o // High while pulling data low
);
  // ==========================================
  // Idle bus: clock stands high, data released to the pull-up
  initial begin
    scl_o = 1'b1;
    pull_o = 1'b0;
  end
  // One 80 ns bit: 60 ns low, 20 ns high; data set early for setup margin
  task automatic bit_x(input logic b, output logic r);
    #5 pull_o = ~b;
    #55 scl_o = 1'b1;
    #10 r = sda_i;
    #10 scl_o = 1'b0;
  endtask
  // Start also serves as repeated start; long high time for the slow detector
  task automatic start_c();
    #5 pull_o = 1'b0;
    #55 scl_o = 1'b1;
    #150 pull_o = 1'b1;
    #150 scl_o = 1'b0;
  endtask
  // Stop leaves the clock high, so it stands still between frames
  task automatic stop_c();
    #5 pull_o = 1'b1;
    #55 scl_o = 1'b1;
    #150 pull_o = 1'b0;
    #300;
  endtask
  // ==========================================
  // Byte transfers, most significant bit first
  task automatic put_byte(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_x(d[i], r);
    end
    bit_x(1'b1, r);
    ack = ~r;
  endtask
  // Last byte of a read is answered with a no-acknowledge
  task automatic get_byte(input logic last, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_x(1'b1, r);
      d[i] = r;
    end
    bit_x(last, r);
  endtask
endmodule

// >>> sim/tb_top.sv
// Self-checking bench for the EEPROM slave port.
// Assumes the master model drives the link; commit shortened to 200 cycles.
`timescale 1ns/100ps
module tb_top import sesp_pkg::*;;
  localparam int WC = 200;
  localparam logic [127:0] UID = 128'h5A5A_0F0F_3C3C_9696_A5A5_F0F0_C3C3_6969; // Arbitrary
  logic sys_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic wp = 1'b0;
  logic [2:0] straps = 3'h0;
  logic scl;
  logic pull;
  logic sda;
  logic sda_o;
  logic sda_oe_n;
  logic busy;
  int fails = 0;
  int n_compared = 0;
  // ==========================================
  // Clock, wired-AND data line, device and master
  always #5 sys_clk = ~sys_clk;
  assign sda = ~pull & sda_oe_n;
  sesp_top #(.WRITE_CYCLES(WC), .UNIQUE_ID(UID)) uut (
    .SYS_CLK_I(sys_clk), .SYS_RST_I(sys_rst), .SCL_CLK_I(scl), .SDA_I(sda),
    .SDA_O(sda_o), .SDA_OE_N_O(sda_oe_n), .CHIP_SELECT_BIT_0_I(straps[0]),
    .CHIP_SELECT_BIT_1_I(straps[1]), .CHIP_SELECT_BIT_2_I(straps[2]),
    .WRITE_PROTECT_I(wp), .BUSY_O(busy));
  sesp_master mst (.sda_i(sda), .scl_o(scl), .pull_o(pull));
  // ==========================================
  // Comparisons and verdict
  task automatic chk_bit(input string what, input logic exp, input logic got);
    n_compared++;
    if (got !== exp) begin
      fails++;
      $display("wrong value %s expected %b seen %b", what, exp, got);
    end
  endtask
  task automatic chk_byte(input string what, input logic [7:0] exp, input logic [7:0] got);
    n_compared++;
    if (got !== exp) begin
      fails++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic conclude;
    $display("Compared %0d, mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  // ==========================================
  // Frame helpers
  task automatic open_at(input logic [3:0] t, input logic [14:0] a);
    logic ack;
    mst.start_c();
    mst.put_byte({t, straps, 1'b0}, ack);
    chk_bit("device ack", 1'b1, ack);
    mst.put_byte({1'b0, a[14:8]}, ack);
    chk_bit("high address ack", 1'b1, ack);
    mst.put_byte(a[7:0], ack);
    chk_bit("low address ack", 1'b1, ack);
  endtask
  // Bounded wait for the commit to finish
  task automatic wait_idle(output int n);
    n = 0;
    while (busy !== 1'b0 && n < WC + 100) begin
      @(posedge sys_clk);
      n++;
    end
    chk_bit("busy ends", 1'b0, busy);
    repeat (5) @(posedge sys_clk);
  endtask
  task automatic wr(input logic [3:0] t, input logic [14:0] a, input logic [7:0] d[$],
                    input logic dack, input logic poll);
    logic ack;
    int n;
    open_at(t, a);
    foreach (d[i]) begin
      mst.put_byte(d[i], ack);
      chk_bit("data ack", dack, ack);
    end
    mst.stop_c();
    if (dack) begin
      chk_bit("busy after stop", 1'b1, busy);
    end
    if (dack && poll) begin
      mst.start_c();
      mst.put_byte({t, straps, 1'b0}, ack);
      chk_bit("ack while busy", 1'b0, ack);
      mst.stop_c();
    end
    wait_idle(n);
    if (dack && !poll) begin
      chk_bit("commit length", 1'b1, n > WC - 40 && n <= WC);
    end
  endtask
  task automatic rd(input logic [3:0] t, input logic [14:0] a, input logic [7:0] e[$]);
    logic ack;
    logic [7:0] d;
    open_at(t, a);
    mst.start_c();
    mst.put_byte({t, straps, 1'b1}, ack);
    chk_bit("read device ack", 1'b1, ack);
    foreach (e[i]) begin
      mst.get_byte(i == e.size() - 1, d);
      chk_byte("read data", e[i], d);
    end
    mst.stop_c();
  endtask
  // ==========================================
  // Scenarios
  // Every strap setting; one flipped strap or a foreign type is refused
  task automatic t_straps;
    logic ack;
    int n;
    for (int s = 7; s >= 0; s--) begin
      @(posedge sys_clk) straps <= 3'(s);
      repeat (2) @(posedge sys_clk);
      mst.start_c();
      mst.put_byte({TYPE_MAIN, 3'(s) ^ (3'h1 << (s % 3)), 1'b0}, ack);
      chk_bit("wrong strap ack", 1'b0, ack);
      mst.stop_c();
      mst.start_c();
      mst.put_byte({4'hC, 3'(s), 1'b0}, ack);
      chk_bit("wrong type ack", 1'b0, ack);
      mst.stop_c();
      mst.start_c();
      mst.put_byte({TYPE_MAIN, 3'(s), 1'b0}, ack);
      chk_bit("strap match ack", 1'b1, ack);
      mst.stop_c();
      wait_idle(n);
    end
  endtask
  // Page write running off the page end wraps to the page start
  task automatic t_page;
    wr(TYPE_MAIN, 15'h123E, {8'hA1, 8'hB2, 8'hC3}, 1'b1, 1'b0);
    rd(TYPE_MAIN, 15'h123E, {8'hA1, 8'hB2});
    rd(TYPE_MAIN, 15'h1200, {8'hC3});
  endtask
  // Last page, ack polling, then a protected write leaves old data
  task automatic t_protect;
    wr(TYPE_MAIN, 15'h7FC0, {8'h11}, 1'b1, 1'b1);
    @(posedge sys_clk) wp <= 1'b1;
    wr(TYPE_MAIN, 15'h7FC0, {8'h5A, 8'h5B}, 1'b0, 1'b0);
    rd(TYPE_MAIN, 15'h7FC0, {8'h11});
    @(posedge sys_clk) wp <= 1'b0;
  endtask
  // Id page written, locked, rewrite refused; serial number read
  task automatic t_id;
    wr(TYPE_ID, 15'h0005, {8'hC3}, 1'b1, 1'b0);
    rd(TYPE_ID, 15'h0005, {8'hC3});
    wr(TYPE_ID, 15'h0400, {8'h00}, 1'b1, 1'b0);
    wr(TYPE_ID, 15'h0005, {8'h3C}, 1'b0, 1'b0);
    rd(TYPE_ID, 15'h0005, {8'hC3});
    rd(TYPE_ID, 15'h0800, {UID[127:120], UID[119:112], UID[111:104]});
  endtask
  // ==========================================
  // Main sequence; straps end at zero, the floating case
  initial begin
    repeat (3) @(posedge sys_clk);
    sys_rst <= 1'b0;
    repeat (6) @(posedge sys_clk);
    chk_bit("idle line drive", 1'b1, sda_oe_n);
    chk_bit("idle busy", 1'b0, busy);
    t_straps();
    t_page();
    t_protect();
    t_id();
    chk_bit("drive value", 1'b0, sda_o);
    conclude();
  end
  // Watchdog: the run needs well under 300 us
  initial begin
    #600000;
    fails++;
    conclude();
  end
endmodule
